// ==== sbe_status_mask.sv ====
/*
 * Secondary bus uncorrectable error status, mask and severity registers
 * with message, header log and first error pointer reporting.
 * Assumes one config request at a time, answered one cycle later, and
 * error events given as one-cycle strobes synchronous to CLK_SYS.
 */
`timescale 1ns/1ps
`include "sbe_cfg.svh"

module sbe_status_mask (
   // clock and resets
   input  wire logic                  CLK_SYS,
   input  wire logic                  RST,
   input  wire logic                  PCIE_RESET_N,
   input  wire logic                  GLOBAL_RESET_PIN_N,
   // configuration access
   input  wire sbe_pkg::sbe_cfg_req_t CFG_REQ,
   output sbe_pkg::sbe_cfg_rsp_t      CFG_RSP,
   // secondary bus events
   input  wire sbe_pkg::sbe_events_t  SEC_EVENTS,
   // error reporting
   output sbe_pkg::sbe_msg_t          ERR_MSG,
   output logic                       HDR_LOG_LOAD,
   output logic [`SBE_PTR_W-1:0]      FIRST_ERR_PTR,
   output logic                       FIRST_ERR_VALID,
   // fundamental reset state
   output logic                       FUNDAMENTAL_RESET_N
);

   import sbe_pkg::*;

   // sticky register state
   logic [31:0]              status;
   logic [31:0]              mask;
   logic [31:0]              severity;
   logic [`SBE_PTR_W-1:0]    first_ptr;
   logic                     first_valid;

   // next values
   logic [31:0]              next_status;
   logic [31:0]              next_mask;
   logic [31:0]              next_severity;

   // decode and event terms
   logic                     fundamental_reset_n;
   logic                     wr_status;
   logic                     wr_mask;
   logic                     wr_severity;
   logic [31:0]              lane_bits;
   logic [31:0]              raw_events;
   logic [31:0]              hits;
   logic [31:0]              clear_bits;
   logic [31:0]              read_value;
   logic                     any_fatal;
   logic                     any_nonfatal;
   logic [`SBE_PTR_W-1:0]    first_pos;
   logic                     ptr_stale;

   // byte enables widened to a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // merge write data into a register through lanes and writable bits
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdata,
                                         input logic [31:0] lane_m,
                                         input logic [31:0] rw_m);
      logic [31:0] sel;
      sel = lane_m & rw_m;
      return (old & ~sel) | (wdata & sel);
   endfunction

   // events placed at their status positions
   function automatic logic [31:0] place(input sbe_events_t ev);
      logic [31:0] v;
      v = '0;
      v[`SBE_BIT_SYS_ERR]   = ev.system_error_seen;
      v[`SBE_BIT_PAR_SIG]   = ev.parity_signal_seen;
      v[`SBE_BIT_DISCARD]   = ev.discard_expired;
      v[`SBE_BIT_ADDR_PAR]  = ev.address_phase_parity_fault;
      v[`SBE_BIT_DATA_PAR]  = ev.data_phase_parity_fault
                            | ev.read_completion_parity_seen;
      v[`SBE_BIT_MST_ABORT] = ev.master_abort_received;
      v[`SBE_BIT_TGT_ABORT] = ev.target_abort_received;
      return v;
   endfunction

   // fundamental reset from the two reset pins
   sbe_rst_sync u_rst_sync (
      .clk                 (CLK_SYS),
      .pcie_reset_n        (PCIE_RESET_N),
      .global_reset_pin_n  (GLOBAL_RESET_PIN_N),
      .fundamental_reset_n (fundamental_reset_n)
   );

   // severity split and first position of new errors
   sbe_report #(
      .PTR_W        (`SBE_PTR_W)
   ) u_report (
      .hits         (hits),
      .severity     (severity),
      .any_fatal    (any_fatal),
      .any_nonfatal (any_nonfatal),
      .first_pos    (first_pos)
   );

   // address decode
   always_comb begin
      wr_status   = 1'b0;
      wr_mask     = 1'b0;
      wr_severity = 1'b0;
      if (CFG_REQ.valid && CFG_REQ.write) begin
         if (CFG_REQ.addr == `SBE_OFS_STATUS) begin
            wr_status = 1'b1;
         end else if (CFG_REQ.addr == `SBE_OFS_MASK) begin
            wr_mask = 1'b1;
         end else if (CFG_REQ.addr == `SBE_OFS_SEVERITY) begin
            wr_severity = 1'b1;
         end
      end
   end

   assign lane_bits = lanes(CFG_REQ.be);

   // only unmasked, implemented errors are recorded
   always_comb begin
      raw_events = place(SEC_EVENTS);
      hits       = raw_events & ~mask & `SBE_STATUS_IMPL;
   end

   // write one clears; zero leaves the bit alone
   always_comb begin
      clear_bits = '0;
      if (wr_status) begin
         clear_bits = CFG_REQ.wdata & lane_bits & `SBE_STATUS_IMPL;
      end
   end

   // a new event wins over a clear in the same cycle
   always_comb begin
      next_status = ((status & ~clear_bits) | hits) & `SBE_STATUS_IMPL;
   end

   always_comb begin
      next_mask = mask;
      if (wr_mask) begin
         next_mask = merge(mask, CFG_REQ.wdata, lane_bits, `SBE_MASK_RW);
      end
   end

   always_comb begin
      next_severity = severity;
      if (wr_severity) begin
         next_severity = merge(severity, CFG_REQ.wdata, lane_bits, `SBE_SEVERITY_RW);
      end
   end

   // status register, sticky
   always_ff @(posedge CLK_SYS or negedge fundamental_reset_n) begin
      if (!fundamental_reset_n) begin
         status <= `SBE_RST_STATUS;
      end else begin
         status <= next_status;
      end
   end

   // mask register, sticky
   always_ff @(posedge CLK_SYS or negedge fundamental_reset_n) begin
      if (!fundamental_reset_n) begin
         mask <= `SBE_RST_MASK;
      end else begin
         mask <= next_mask;
      end
   end

   // severity register, sticky
   always_ff @(posedge CLK_SYS or negedge fundamental_reset_n) begin
      if (!fundamental_reset_n) begin
         severity <= `SBE_RST_SEVERITY;
      end else begin
         severity <= next_severity;
      end
   end

   // pointer goes stale once its status bit is cleared
   assign ptr_stale = first_valid && !next_status[first_ptr];

   // first error pointer, sticky
   always_ff @(posedge CLK_SYS or negedge fundamental_reset_n) begin
      if (!fundamental_reset_n) begin
         first_ptr   <= '0;
         first_valid <= 1'b0;
      end else if ((!first_valid || ptr_stale) && (|hits)) begin
         first_ptr   <= first_pos;
         first_valid <= 1'b1;
      end else if (ptr_stale) begin
         first_valid <= 1'b0;
      end
   end

   // readback with reserved bits as zero
   always_comb begin
      read_value = '0;
      if (CFG_REQ.addr == `SBE_OFS_STATUS) begin
         read_value = status & `SBE_STATUS_IMPL;
      end else if (CFG_REQ.addr == `SBE_OFS_MASK) begin
         read_value = mask & `SBE_MASK_RW;
      end else if (CFG_REQ.addr == `SBE_OFS_SEVERITY) begin
         read_value = severity & `SBE_SEVERITY_RW;
      end
   end

   // config answer one cycle after the request
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         CFG_RSP <= '0;
      end else begin
         CFG_RSP.ack <= CFG_REQ.valid;
         if (CFG_REQ.valid && !CFG_REQ.write) begin
            CFG_RSP.rdata <= read_value;
         end else begin
            CFG_RSP.rdata <= '0;
         end
      end
   end

   // error messages, one pulse per cycle with new unmasked errors
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ERR_MSG <= '0;
      end else begin
         ERR_MSG.fatal    <= any_fatal;
         ERR_MSG.nonfatal <= any_nonfatal;
      end
   end

   // header log load strobe
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         HDR_LOG_LOAD <= 1'b0;
      end else begin
         HDR_LOG_LOAD <= |hits;
      end
   end

   // pointer and reset state copies
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         FIRST_ERR_PTR       <= '0;
         FIRST_ERR_VALID     <= 1'b0;
         FUNDAMENTAL_RESET_N <= 1'b0;
      end else begin
         FIRST_ERR_PTR       <= first_ptr;
         FIRST_ERR_VALID     <= first_valid;
         FUNDAMENTAL_RESET_N <= fundamental_reset_n;
      end
   end

endmodule // sbe_status_mask

// ==== sbe_cfg.svh ====
/*
 * Constants for the secondary bus error status and mask block: config
 * offsets, field positions, reset values, writable masks.
 * Assumes a 12-bit extended config address and 32-bit config data words.
 */
`ifndef SBE_CFG_SVH
`define SBE_CFG_SVH

// config offsets
`define SBE_OFS_STATUS      12'h12C
`define SBE_OFS_MASK        12'h130
`define SBE_OFS_SEVERITY    12'h134

// reset values
`define SBE_RST_STATUS      32'h0000_0000
`define SBE_RST_MASK        32'h0000_17A8
`define SBE_RST_SEVERITY    32'h0000_1340

// implemented and writable bits
`define SBE_STATUS_IMPL     32'h0000_1E8C
`define SBE_MASK_RW         32'h0000_3FEE
`define SBE_SEVERITY_RW     32'h0000_3FEE

// status field positions
`define SBE_BIT_SYS_ERR     12
`define SBE_BIT_PAR_SIG     11
`define SBE_BIT_DISCARD     10
`define SBE_BIT_ADDR_PAR    9
`define SBE_BIT_DATA_PAR    7
`define SBE_BIT_MST_ABORT   3
`define SBE_BIT_TGT_ABORT   2

// widths
`define SBE_ADDR_W          12
`define SBE_PTR_W           5

`endif

// ==== sbe_pkg.sv ====
/*
 * Types shared by the secondary bus error status and mask block.
 * Assumes sbe_cfg.svh supplies the widths.
 */
`include "sbe_cfg.svh"

package sbe_pkg;

   // one config access request
   typedef struct packed {
      logic                     valid;
      logic                     write;
      logic [`SBE_ADDR_W-1:0]   addr;
      logic [3:0]               be;
      logic [31:0]              wdata;
   } sbe_cfg_req_t;

   // config access answer
   typedef struct packed {
      logic                     ack;
      logic [31:0]              rdata;
   } sbe_cfg_rsp_t;

   // secondary bus error events, one-cycle strobes
   typedef struct packed {
      logic system_error_seen;
      logic parity_signal_seen;
      logic discard_expired;
      logic address_phase_parity_fault;
      logic data_phase_parity_fault;
      logic read_completion_parity_seen;
      logic master_abort_received;
      logic target_abort_received;
   } sbe_events_t;

   // error message request toward the upstream link
   typedef struct packed {
      logic fatal;
      logic nonfatal;
   } sbe_msg_t;

endpackage

// ==== sbe_rst_sync.sv ====
/*
 * Fundamental reset generator: asserts at once when either reset pin is
 * low, releases two clock edges after both are high.
 * Assumes both pins are active low.
 */
`timescale 1ns/1ps

module sbe_rst_sync (
   // clock
   input  wire logic clk,
   // reset pins
   input  wire logic pcie_reset_n,
   input  wire logic global_reset_pin_n,
   // combined reset
   output logic      fundamental_reset_n
);

   logic raw_reset_n;
   logic hold_n;

   // either source asserts the fundamental reset
   assign raw_reset_n = pcie_reset_n & global_reset_pin_n;

   always_ff @(posedge clk or negedge raw_reset_n) begin
      if (!raw_reset_n) begin
         hold_n              <= 1'b0;
         fundamental_reset_n <= 1'b0;
      end else begin
         hold_n              <= 1'b1;
         fundamental_reset_n <= hold_n;
      end
   end

endmodule // sbe_rst_sync

// ==== sbe_report.sv ====
/*
 * Error classifier: splits the newly recorded errors into fatal and
 * nonfatal by severity, and picks the position of the first one.
 * Assumes hits holds only unmasked, implemented status positions.
 */
`timescale 1ns/1ps

module sbe_report #(
   parameter int PTR_W = 5
) (
   // new unmasked errors
   input  wire logic [31:0]      hits,
   input  wire logic [31:0]      severity,
   // classification
   output logic                  any_fatal,
   output logic                  any_nonfatal,
   output logic [PTR_W-1:0]      first_pos
);

   // highest set position wins when several arrive together
   function automatic logic [PTR_W-1:0] top_bit(input logic [31:0] v);
      logic [PTR_W-1:0] pos;
      pos = '0;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            pos = PTR_W'(i);
         end
      end
      return pos;
   endfunction

   always_comb begin
      any_fatal    = |(hits & severity);
      any_nonfatal = |(hits & ~severity);
      first_pos    = top_bit(hits);
   end

endmodule // sbe_report

// ==== sbe_status_mask_end.sv ====
/*
 * Holds no code; the block's logic lives in sbe_status_mask.sv.
 * Assumes nothing of its surroundings.
 */

// ==== sbe_status_mask_monitor.sv ====
/* port checker for the secondary bus error status and mask block
   assumes it is bound onto sbe_status_mask */
`timescale 1ns/1ps
`include "sbe_cfg.svh"
module sbe_status_mask_monitor (
   // clock and resets
   input wire logic                  CLK_SYS,
   input wire logic                  RST,
   input wire logic                  PCIE_RESET_N,
   input wire logic                  GLOBAL_RESET_PIN_N,
   // config access and events
   input wire sbe_pkg::sbe_cfg_req_t CFG_REQ,
   input wire sbe_pkg::sbe_cfg_rsp_t CFG_RSP,
   input wire sbe_pkg::sbe_events_t  SEC_EVENTS,
   // reporting
   input wire sbe_pkg::sbe_msg_t     ERR_MSG,
   input wire logic                  HDR_LOG_LOAD,
   input wire logic [`SBE_PTR_W-1:0] FIRST_ERR_PTR,
   input wire logic                  FIRST_ERR_VALID,
   input wire logic                  FUNDAMENTAL_RESET_N
);
   import sbe_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic [2:0] quiet;
   wire        pins_hi = PCIE_RESET_N && GLOBAL_RESET_PIN_N;
   // cycles since the last config write
   always_ff @(posedge CLK_SYS or posedge RST)
      if (RST) quiet <= 3'h0;
      else if (CFG_REQ.valid && CFG_REQ.write) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   sequence rd_at(logic [11:0] a);
      CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.addr == a;
   endsequence
   sequence released;
      $rose(pins_hi) ##1 pins_hi [*2];
   endsequence
   ack_follows_a: assert property (CFG_REQ.valid |=> CFG_RSP.ack)
      else $error("request not acked");
   ack_unasked_a: assert property (!CFG_REQ.valid |=> !CFG_RSP.ack)
      else $error("ack without request");
   status_rsvd_a: assert property (rd_at(12'h12C) |=> !(|(CFG_RSP.rdata & 32'hFFFF_E173)))
      else $error("status reserved bit read as one");
   mask_rsvd_a: assert property (rd_at(12'h130) |=> !(|(CFG_RSP.rdata & 32'hFFFF_C011)))
      else $error("mask reserved bit read as one");
   msg_logged_a: assert property ((ERR_MSG.fatal || ERR_MSG.nonfatal) |-> HDR_LOG_LOAD)
      else $error("message without log load");
   log_caused_a: assert property (HDR_LOG_LOAD |-> $past(SEC_EVENTS) != 8'h00)
      else $error("log load without event");
   log_msg_a: assert property (HDR_LOG_LOAD |-> ERR_MSG.fatal || ERR_MSG.nonfatal)
      else $error("log load without message");
   ptr_legal_a: assert property (FIRST_ERR_VALID |-> FIRST_ERR_PTR inside
      {5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h07, 5'h03, 5'h02})
      else $error("pointer off an error position");
   ptr_held_a: assert property (FIRST_ERR_VALID && $past(FIRST_ERR_VALID) && quiet == 3'h7
      |-> $stable(FIRST_ERR_PTR))
      else $error("pointer moved while valid");
   fund_low_a: assert property (!pins_hi |=> !FUNDAMENTAL_RESET_N)
      else $error("fundamental reset not asserted");
   fund_hold_a: assert property (released |-> !FUNDAMENTAL_RESET_N)
      else $error("fundamental reset released early");
   fund_rise_a: assert property (released ##1 pins_hi |-> FUNDAMENTAL_RESET_N)
      else $error("fundamental reset released late");
endmodule // sbe_status_mask_monitor
bind sbe_status_mask sbe_status_mask_monitor u_mon (.CLK_SYS(CLK_SYS), .RST(RST),
   .PCIE_RESET_N(PCIE_RESET_N), .GLOBAL_RESET_PIN_N(GLOBAL_RESET_PIN_N),
   .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP), .SEC_EVENTS(SEC_EVENTS), .ERR_MSG(ERR_MSG),
   .HDR_LOG_LOAD(HDR_LOG_LOAD), .FIRST_ERR_PTR(FIRST_ERR_PTR),
   .FIRST_ERR_VALID(FIRST_ERR_VALID), .FUNDAMENTAL_RESET_N(FUNDAMENTAL_RESET_N));

// ==== sbe_sec_agent.sv ====
/* secondary bus agents: turn an event code into one strobe
   assumes fire is raised for one clock at a time */
`timescale 1ns/1ps
module sbe_sec_agent (
   // control
   input  wire logic            fire,
   input  wire logic [2:0]      code,
   // strobes toward the bridge
   output sbe_pkg::sbe_events_t events
);
   import sbe_pkg::*;
   // code 0 is the top struct field, code 7 the bottom
   always_comb events = fire ? sbe_events_t'(8'h80 >> code) : 8'h00;
endmodule // sbe_sec_agent

// ==== tb.sv ====
/* self-checking bench for sbe_status_mask
   assumes sbe_sec_agent raises the event strobes */
`timescale 1ns/1ps
`include "sbe_cfg.svh"
module tb;
   import sbe_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  rst = 1'b1;
   logic                  pcie_n = 1'b0;
   logic                  glob_n = 1'b0;
   logic                  fire = 1'b0;
   logic [2:0]            code = 3'h0;
   sbe_cfg_req_t          req = '0;
   sbe_cfg_rsp_t          rsp;
   sbe_events_t           ev;
   sbe_msg_t              msg;
   logic                  log_ld;
   logic                  pval;
   logic                  frn;
   logic [`SBE_PTR_W-1:0] ptr;
   logic [31:0]           rd;
   int                    mismatches = 0;
   int                    tests_run = 0;
   int                    cycles = 0;
   logic [4:0] pos [8] = '{5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h07, 5'h07, 5'h03, 5'h02};
   always #50 clk_sys = ~clk_sys;
   sbe_sec_agent u_agent (.fire(fire), .code(code), .events(ev));
   sbe_status_mask u_dut (.CLK_SYS(clk_sys), .RST(rst), .PCIE_RESET_N(pcie_n),
      .GLOBAL_RESET_PIN_N(glob_n), .CFG_REQ(req), .CFG_RSP(rsp), .SEC_EVENTS(ev),
      .ERR_MSG(msg), .HDR_LOG_LOAD(log_ld), .FIRST_ERR_PTR(ptr),
      .FIRST_ERR_VALID(pval), .FUNDAMENTAL_RESET_N(frn));
   task automatic wrap_up();
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cfg(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      req = '{1'b1, wr, a, 4'hF, d};
      @(negedge clk_sys);
      req = '0;
      check({31'h0, rsp.ack}, 32'h1);
      rd = rsp.rdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      cfg(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic hit(input logic [2:0] k, input logic [1:0] em, input logic el);
      @(negedge clk_sys);
      code = k;
      fire = 1'b1;
      @(negedge clk_sys);
      fire = 1'b0;
      check({30'h0, msg}, {30'h0, em});
      check({31'h0, log_ld}, {31'h0, el});
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      pcie_n = 1'b1;
      glob_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      rdchk(`SBE_OFS_STATUS, 32'h0000_0000);
      rdchk(`SBE_OFS_MASK, 32'h0000_17A8);
      rdchk(12'h200, 32'h0000_0000);
      cfg(1'b1, `SBE_OFS_MASK, 32'hFFFF_FFFF);
      rdchk(`SBE_OFS_MASK, 32'h0000_3FEE);
      cfg(1'b1, `SBE_OFS_MASK, 32'h0000_2162);
      for (int k = 0; k < 8; k++) begin
         hit(k[2:0], (pos[k] == 5'h0C || pos[k] == 5'h09) ? 2'b10 : 2'b01, 1'b1);
         if (k == 0) begin
            @(negedge clk_sys);
            check({27'h0, ptr}, 32'h0000_000C);
            check({31'h0, pval}, 32'h1);
         end
         rdchk(`SBE_OFS_STATUS, 32'h1 << pos[k]);
         cfg(1'b1, `SBE_OFS_STATUS, 32'h0000_0000);
         rdchk(`SBE_OFS_STATUS, 32'h1 << pos[k]);
         cfg(1'b1, `SBE_OFS_STATUS, 32'hFFFF_FFFF);
         rdchk(`SBE_OFS_STATUS, 32'h0000_0000);
      end
      hit(3'h6, 2'b01, 1'b1);
      hit(3'h6, 2'b01, 1'b1);
      @(negedge clk_sys);
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      rdchk(`SBE_OFS_STATUS, 32'h0000_0008);
      cfg(1'b1, `SBE_OFS_SEVERITY, 32'h0000_0008);
      hit(3'h6, 2'b10, 1'b1);
      @(negedge clk_sys);
      req = '{1'b1, 1'b1, `SBE_OFS_STATUS, 4'hF, 32'h0000_0008};
      code = 3'h6;
      fire = 1'b1;
      @(negedge clk_sys);
      req = '0;
      fire = 1'b0;
      check({30'h0, msg}, 32'h0000_0002);
      rdchk(`SBE_OFS_STATUS, 32'h0000_0008);
      cfg(1'b1, `SBE_OFS_MASK, 32'h0000_3FEE);
      for (int k = 0; k < 8; k++)
         hit(k[2:0], 2'b00, 1'b0);
      rdchk(`SBE_OFS_STATUS, 32'h0000_0008);
      for (int j = 0; j < 2; j++) begin
         cfg(1'b1, `SBE_OFS_MASK, 32'h0000_0000);
         hit(3'h7, 2'b01, 1'b1);
         @(negedge clk_sys);
         check({27'h0, ptr}, (j == 0) ? 32'h0000_0003 : 32'h0000_0002);
         if (j == 0) pcie_n = 1'b0;
         else glob_n = 1'b0;
         @(negedge clk_sys);
         check({31'h0, frn}, 32'h0000_0000);
         pcie_n = 1'b1;
         glob_n = 1'b1;
         repeat (4) @(negedge clk_sys);
         check({31'h0, frn}, 32'h0000_0001);
         rdchk(`SBE_OFS_STATUS, 32'h0000_0000);
         rdchk(`SBE_OFS_MASK, 32'h0000_17A8);
         check({31'h0, pval}, 32'h0000_0000);
      end
      wrap_up();
   end
endmodule // tb
